// File: rtl/icu_pair.sv
// pairs of input capture channels: edge timestamping into small fifos
// assumes inputs synchronous to clk_sys except capture_input (synchronised here)
`timescale 1ns/1ns

module icu_pair #(
   parameter int NPAIR = 1,
   parameter int DEPTH = icu_pkg::ICU_FIFO_DEPTH
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [2*NPAIR-1:0][15:0] capture_control_one,
   input wire logic [2*NPAIR-1:0][15:0] capture_control_two,
   input wire logic [2*NPAIR-1:0] trigger_status_clear,
   input wire logic [2*NPAIR-1:0] overflow_clear,
   input wire logic [2*NPAIR-1:0] fifo_pop,
   input wire logic [2*NPAIR-1:0] capture_input,
   input wire logic [icu_pkg::ICU_NTB-1:0] timebase_tick,
   input wire logic [icu_pkg::ICU_NTB-1:0] timebase_on,
   input wire logic [icu_pkg::ICU_NSRC-1:0] sync_event,
   input wire logic [icu_pkg::ICU_NSRC-1:0] sync_source_on,
   output logic [NPAIR-1:0][15:0] capture_fifo_low_word,
   output logic [NPAIR-1:0][15:0] capture_fifo_high_word,
   output logic [2*NPAIR-1:0] fifo_not_empty,
   output logic [2*NPAIR-1:0] capture_irq,
   output icu_pkg::icu_sts_s [2*NPAIR-1:0] status,
   output logic [2*NPAIR-1:0][15:0] capture_control_one_rd
);

   localparam int NCH = 2 * NPAIR;
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
   localparam logic [CW-1:0] CNT_ZERO = '0;
   localparam logic [PW-1:0] PTR_ZERO = '0;

   // ----------------------------------------------------------------
   // per channel decode and cross-channel views
   // ----------------------------------------------------------------
   icu_pkg::icu_ctl_s [NCH-1:0] ctl;
   icu_pkg::icu_state_e own_st_nxt [NCH];
   icu_pkg::icu_state_e u_st_nxt [NCH];
   icu_pkg::icu_state_e st_ff [NCH];
   logic [NCH-1:0] own_on;
   logic [NCH-1:0] own_tick;
   logic [NCH-1:0] own_zero;
   logic [NCH-1:0] own_ev;
   logic [NCH-1:0] own_roll;
   logic [NCH-1:0] own_arm_nxt;
   logic [NCH-1:0] u_tick;
   logic [NCH-1:0] u_zero;
   logic [NCH-1:0] u_ev;
   logic [NCH-1:0] u_irq_ok;
   logic [NCH-1:0] armed_ff;
   logic [NCH-1:0][2:0] sync_ff;
   logic [NCH-1:0][3:0] pre_ff;
   logic [NCH-1:0][15:0] tmr_ff;
   logic [NCH-1:0][15:0] head;

   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         logic rise;
         logic fall;
         logic hit;
         logic src_ok;

         assign ctl[g].capture_mode_select =
            capture_control_one[g][icu_pkg::ICU_C1_MODE_LSB +: 3];
         assign ctl[g].interrupt_divider =
            capture_control_one[g][icu_pkg::ICU_C1_IDIV_LSB +: 2];
         assign ctl[g].timebase_clock_select =
            capture_control_one[g][icu_pkg::ICU_C1_TSEL_LSB +: 3];
         assign ctl[g].sync_source_select =
            capture_control_two[g][icu_pkg::ICU_C2_SSEL_LSB +: 5];
         assign ctl[g].trigger_mode_select =
            capture_control_two[g][icu_pkg::ICU_C2_TRIG_BIT];
         assign ctl[g].cascade_enable =
            capture_control_two[g][icu_pkg::ICU_C2_CASC_BIT];

         // edge detect on the second and third stage only
         assign rise = sync_ff[g][1] & ~sync_ff[g][2];
         assign fall = ~sync_ff[g][1] & sync_ff[g][2];

         assign src_ok = (ctl[g].sync_source_select == icu_pkg::ICU_SYNC_FREE) |
            sync_source_on[ctl[g].sync_source_select];
         assign own_on[g] = timebase_on[ctl[g].timebase_clock_select] & src_ok &
            (ctl[g].capture_mode_select != icu_pkg::ICU_MODE_OFF);
         assign own_tick[g] = timebase_tick[ctl[g].timebase_clock_select];
         assign hit = (ctl[g].sync_source_select != icu_pkg::ICU_SYNC_FREE) &
            sync_event[ctl[g].sync_source_select];
         assign own_roll[g] = (tmr_ff[g] == icu_pkg::ICU_TMR_MAX);

         // set wins over the software clear of the armed flag
         assign own_arm_nxt[g] = own_on[g] & ((ctl[g].trigger_mode_select & hit) |
            (armed_ff[g] & ~trigger_status_clear[g]));
         // sync mode restarts on each sync event; trigger mode on arming
         assign own_zero[g] = hit & (~ctl[g].trigger_mode_select | ~armed_ff[g]);

         always_comb begin
            if (!own_on[g]) begin
               own_st_nxt[g] = icu_pkg::ICU_ST_HELD;
            end else if (!ctl[g].trigger_mode_select || own_arm_nxt[g]) begin
               own_st_nxt[g] = icu_pkg::ICU_ST_RUN;
            end else begin
               own_st_nxt[g] = icu_pkg::ICU_ST_WAIT;
            end
         end

         always_comb begin
            own_ev[g] = 1'b0;
            if (st_ff[g] == icu_pkg::ICU_ST_RUN) begin
               case (ctl[g].capture_mode_select)
                  icu_pkg::ICU_MODE_BOTH: own_ev[g] = rise | fall;
                  icu_pkg::ICU_MODE_RISE: own_ev[g] = rise;
                  icu_pkg::ICU_MODE_RISE4:
                     own_ev[g] = rise & (pre_ff[g][1:0] == icu_pkg::ICU_PRE4_LAST);
                  icu_pkg::ICU_MODE_RISE16:
                     own_ev[g] = rise & (pre_ff[g] == icu_pkg::ICU_PRE16_LAST);
                  default: own_ev[g] = 1'b0;
               endcase
            end
         end

         // even channel of a pair may follow its odd partner
         if (g % 2 == 1) begin : g_even
            logic casc;
            assign casc = ctl[g].cascade_enable & ctl[g-1].cascade_enable;
            assign u_st_nxt[g] = casc ? own_st_nxt[g-1] : own_st_nxt[g];
            assign u_tick[g] = casc ? (own_tick[g-1] & own_roll[g-1]) : own_tick[g];
            assign u_zero[g] = casc ? own_zero[g-1] : own_zero[g];
            assign u_ev[g] = casc ? own_ev[g-1] : own_ev[g];
            assign u_irq_ok[g] = ~casc;
         end else begin : g_odd
            assign u_st_nxt[g] = own_st_nxt[g];
            assign u_tick[g] = own_tick[g];
            assign u_zero[g] = own_zero[g];
            assign u_ev[g] = own_ev[g];
            assign u_irq_ok[g] = 1'b1;
         end

         // ----------------------------------------------------------
         // timer, prescaler, fifo and interrupt state
         // ----------------------------------------------------------
         logic [15:0] mem_ff [DEPTH];
         logic [15:0] nxt_mem [DEPTH];
         logic [PW-1:0] wr_ff;
         logic [PW-1:0] rd_ff;
         logic [CW-1:0] cnt_ff;
         logic [1:0] icnt_ff;
         logic ovf_ff;
         logic irq_ff;
         logic [2:0] nxt_sync;
         logic [3:0] nxt_pre;
         logic [15:0] nxt_tmr;
         icu_pkg::icu_state_e nxt_st;
         logic nxt_armed;
         logic [PW-1:0] nxt_wr;
         logic [PW-1:0] nxt_rd;
         logic [CW-1:0] nxt_cnt;
         logic [1:0] nxt_icnt;
         logic nxt_ovf;
         logic nxt_irq;
         logic pop_ok;
         logic push_ok;

         always_comb begin
            nxt_sync = {sync_ff[g][1:0], capture_input[g]};
            nxt_st = u_st_nxt[g];
            nxt_armed = own_arm_nxt[g];
            nxt_tmr = tmr_ff[g];
            if (u_st_nxt[g] == icu_pkg::ICU_ST_HELD || u_zero[g]) begin
               nxt_tmr = icu_pkg::ICU_TMR_RST;
            end else if (st_ff[g] == icu_pkg::ICU_ST_RUN && u_tick[g]) begin
               nxt_tmr = 16'(tmr_ff[g] + 16'h0001);
            end
            nxt_pre = pre_ff[g];
            if (st_ff[g] != icu_pkg::ICU_ST_RUN) begin
               nxt_pre = icu_pkg::ICU_PRE_RST;
            end else if (rise) begin
               nxt_pre = 4'(pre_ff[g] + 4'h1);
            end
            for (int i = 0; i < DEPTH; i++) begin
               nxt_mem[i] = mem_ff[i];
            end
            pop_ok = fifo_pop[g] & (cnt_ff != CNT_ZERO);
            push_ok = u_ev[g] & ((cnt_ff != CNT_FULL) | pop_ok);
            nxt_wr = wr_ff;
            nxt_rd = rd_ff;
            nxt_cnt = cnt_ff;
            if (push_ok) begin
               nxt_mem[wr_ff] = tmr_ff[g];
               nxt_wr = PW'(wr_ff + 1'b1);
            end
            if (pop_ok) begin
               nxt_rd = PW'(rd_ff + 1'b1);
            end
            if (push_ok && !pop_ok) begin
               nxt_cnt = CW'(cnt_ff + 1'b1);
            end else if (pop_ok && !push_ok) begin
               nxt_cnt = CW'(cnt_ff - 1'b1);
            end
            // a drop in the same cycle as the clear keeps the flag
            nxt_ovf = (u_ev[g] & ~push_ok) | (ovf_ff & ~overflow_clear[g]);
            nxt_icnt = icnt_ff;
            nxt_irq = 1'b0;
            if (st_ff[g] == icu_pkg::ICU_ST_HELD) begin
               nxt_icnt = icu_pkg::ICU_IDIV_RST;
            end else if (u_ev[g] && u_irq_ok[g]) begin
               if (icnt_ff == ctl[g].interrupt_divider) begin
                  nxt_irq = 1'b1;
                  nxt_icnt = icu_pkg::ICU_IDIV_RST;
               end else begin
                  nxt_icnt = 2'(icnt_ff + 2'h1);
               end
            end
         end

         always_ff @(posedge clk_sys) begin
            if (rst) begin
               sync_ff[g] <= 3'h0;
               pre_ff[g] <= icu_pkg::ICU_PRE_RST;
               tmr_ff[g] <= icu_pkg::ICU_TMR_RST;
               st_ff[g] <= icu_pkg::ICU_ST_HELD;
               armed_ff[g] <= 1'b0;
               for (int i = 0; i < DEPTH; i++) begin
                  mem_ff[i] <= icu_pkg::ICU_TMR_RST;
               end
               wr_ff <= PTR_ZERO;
               rd_ff <= PTR_ZERO;
               cnt_ff <= CNT_ZERO;
               icnt_ff <= icu_pkg::ICU_IDIV_RST;
               ovf_ff <= 1'b0;
               irq_ff <= 1'b0;
            end else begin
               sync_ff[g] <= nxt_sync;
               pre_ff[g] <= nxt_pre;
               tmr_ff[g] <= nxt_tmr;
               st_ff[g] <= nxt_st;
               armed_ff[g] <= nxt_armed;
               for (int i = 0; i < DEPTH; i++) begin
                  mem_ff[i] <= nxt_mem[i];
               end
               wr_ff <= nxt_wr;
               rd_ff <= nxt_rd;
               cnt_ff <= nxt_cnt;
               icnt_ff <= nxt_icnt;
               ovf_ff <= nxt_ovf;
               irq_ff <= nxt_irq;
            end
         end

         // ----------------------------------------------------------
         // outputs
         // ----------------------------------------------------------
         assign head[g] = mem_ff[rd_ff];
         assign fifo_not_empty[g] = (cnt_ff != CNT_ZERO);
         assign capture_irq[g] = irq_ff;
         assign status[g].fifo_not_empty = (cnt_ff != CNT_ZERO);
         assign status[g].fifo_overflow = ovf_ff;
         assign status[g].trigger_armed_status = armed_ff[g];
         always_comb begin
            capture_control_one_rd[g] = 16'h0000;
            capture_control_one_rd[g][icu_pkg::ICU_C1_MODE_LSB +: 3] =
               ctl[g].capture_mode_select;
            capture_control_one_rd[g][icu_pkg::ICU_C1_NE_BIT] =
               (cnt_ff != CNT_ZERO);
            capture_control_one_rd[g][icu_pkg::ICU_C1_IDIV_LSB +: 2] =
               ctl[g].interrupt_divider;
            capture_control_one_rd[g][icu_pkg::ICU_C1_TSEL_LSB +: 3] =
               ctl[g].timebase_clock_select;
         end
      end

      // odd channel gives the low word, even channel the high word
      for (g = 0; g < NPAIR; g++) begin : g_pair
         assign capture_fifo_low_word[g] = head[2*g];
         assign capture_fifo_high_word[g] = head[2*g+1];
      end
   endgenerate

endmodule : icu_pair

// File: rtl/icu_pkg.sv
// constants, field layouts and carrier types of the input capture unit
// assumes one clock domain; time base ticks arrive as one-cycle enables
package icu_pkg;

   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int ICU_TW = 16;
   localparam int ICU_FIFO_DEPTH = 4;
   localparam int ICU_NTB = 8;
   localparam int ICU_NSRC = 32;

   // ----------------------------------------------------------------
   // field positions of control words one and two
   // ----------------------------------------------------------------
   localparam int ICU_C1_MODE_LSB = 0;
   localparam int ICU_C1_NE_BIT = 3;
   localparam int ICU_C1_IDIV_LSB = 5;
   localparam int ICU_C1_TSEL_LSB = 10;
   localparam int ICU_C2_SSEL_LSB = 0;
   localparam int ICU_C2_TSTAT_BIT = 6;
   localparam int ICU_C2_TRIG_BIT = 7;
   localparam int ICU_C2_CASC_BIT = 8;

   // ----------------------------------------------------------------
   // encodings and reset values
   // ----------------------------------------------------------------
   localparam logic [2:0] ICU_MODE_OFF = 3'h0;
   localparam logic [2:0] ICU_MODE_BOTH = 3'h1;
   localparam logic [2:0] ICU_MODE_RISE = 3'h3;
   localparam logic [2:0] ICU_MODE_RISE4 = 3'h4;
   localparam logic [2:0] ICU_MODE_RISE16 = 3'h5;
   localparam logic [1:0] ICU_PRE4_LAST = 2'h3;
   localparam logic [3:0] ICU_PRE16_LAST = 4'hf;
   localparam logic [3:0] ICU_PRE_RST = 4'h0;
   localparam logic [4:0] ICU_SYNC_FREE = 5'h00;
   localparam logic [15:0] ICU_TMR_RST = 16'h0000;
   localparam logic [15:0] ICU_TMR_MAX = 16'hffff;
   localparam logic [1:0] ICU_IDIV_RST = 2'h0;

   typedef enum logic [1:0] {
      ICU_ST_HELD = 2'b00,
      ICU_ST_WAIT = 2'b01,
      ICU_ST_RUN = 2'b11
   } icu_state_e;

   typedef struct packed {
      logic cascade_enable;
      logic trigger_mode_select;
      logic [4:0] sync_source_select;
      logic [2:0] timebase_clock_select;
      logic [1:0] interrupt_divider;
      logic [2:0] capture_mode_select;
   } icu_ctl_s;

   typedef struct packed {
      logic fifo_not_empty;
      logic fifo_overflow;
      logic trigger_armed_status;
   } icu_sts_s;

endpackage : icu_pkg

// File: verification/icu_edge_src.sv
// far-side model: capture pin driver and time base tick source
// assumes clk_sys is the capture unit clock; the pin itself is asynchronous
`timescale 1ns/1ns
module icu_edge_src #(
   parameter int TICK_DIV = 1
) (
   input wire logic clk_sys,
   input wire logic toggle_req,
   output logic pin,
   output logic [7:0] tick
);
   int cnt = 0;
   initial pin = 1'b0;
   initial tick = 8'h00;
   // pin flips once per request; ticks every TICK_DIV cycles
   always @(posedge clk_sys) begin
      if (toggle_req) pin <= ~pin;
      cnt <= (cnt + 1 >= TICK_DIV) ? 0 : cnt + 1;
      tick <= (cnt + 1 >= TICK_DIV) ? 8'hff : 8'h00;
   end
endmodule : icu_edge_src

// File: verification/icu_pair_props.sv
// assertion checker for icu_pair, watching pair 0 only
// assumes bind to the top module's ports
`timescale 1ns/1ns
module icu_pair_props #(
   parameter int NPAIR = 1
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [2*NPAIR-1:0][15:0] capture_control_one,
   input wire logic [2*NPAIR-1:0][15:0] capture_control_two,
   input wire logic [2*NPAIR-1:0] overflow_clear,
   input wire logic [2*NPAIR-1:0] fifo_pop,
   input wire logic [2*NPAIR-1:0] fifo_not_empty,
   input wire logic [2*NPAIR-1:0] capture_irq,
   input icu_pkg::icu_sts_s [2*NPAIR-1:0] status,
   input wire logic [2*NPAIR-1:0][15:0] capture_control_one_rd
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_ne_echo_bit: assert property (capture_control_one_rd[0] ==
      ((capture_control_one[0] & 16'h1c67) | {12'h000, fifo_not_empty[0], 3'h0}))
      else $error("control echo differs");
   a_mode_gates_capture: assert property ($rose(fifo_not_empty[0]) |->
      $past(capture_control_one[0][2:0]) != 3'h0) else $error("capture while mode off");
   a_irq_has_data: assert property (capture_irq[0] |-> fifo_not_empty[0])
      else $error("irq without data");
   a_irq_every_event: assert property ($rose(fifo_not_empty[0]) &&
      $past(capture_control_one[0][6:5]) == 2'h0 |-> capture_irq[0]) else $error("irq missed");
   a_ne_holds: assert property (fifo_not_empty[0] && !fifo_pop[0] |=> fifo_not_empty[0])
      else $error("not-empty dropped without pop");
   a_ne_falls_pop: assert property ($fell(fifo_not_empty[0]) |->
      $past(fifo_pop[0]) || $past(rst)) else $error("not-empty fell without pop");
   a_ovf_when_full: assert property ($rose(status[0].fifo_overflow) |->
      $past(fifo_not_empty[0])) else $error("overflow while empty");
   a_ovf_sticks: assert property (status[0].fifo_overflow && !overflow_clear[0] |=>
      status[0].fifo_overflow) else $error("overflow lost");
   a_even_irq_quiet: assert property (capture_control_two[0][8] && capture_control_two[1][8]
      && $past(capture_control_two[0][8] && capture_control_two[1][8]) |-> !capture_irq[1])
      else $error("even irq while cascaded");
endmodule : icu_pair_props

bind icu_pair icu_pair_props #(.NPAIR(NPAIR)) i_props (.clk_sys, .rst, .capture_control_one,
   .capture_control_two, .overflow_clear, .fifo_pop, .fifo_not_empty, .capture_irq, .status,
   .capture_control_one_rd);

// File: verification/test_icu_pair.sv
// self-checking bench for icu_pair with one pair of channels
// assumes icu_edge_src drives the pin and time base ticks
`timescale 1ns/1ns
module test_icu_pair;
   localparam logic [2:0] BOTH = icu_pkg::ICU_MODE_BOTH;
   localparam logic [2:0] RISE = icu_pkg::ICU_MODE_RISE;
   logic clk_sys, rst, tog, p0;
   logic [1:0][15:0] ctl1, ctl2, rd1;
   logic [1:0] tsc, ovc, pop, ne, irq;
   logic [7:0] tb_on, tick;
   logic [31:0] sev, son, a, b;
   logic [0:0][15:0] lo, hi;
   icu_pkg::icu_sts_s [1:0] sts;
   int error_cnt, checks_done, irqs, irq_base;
   logic [2:0] mds [3] = '{icu_pkg::ICU_MODE_RISE, icu_pkg::ICU_MODE_RISE4,
      icu_pkg::ICU_MODE_RISE16};
   int cnts [3] = '{1, 4, 16};

   icu_edge_src i_src (.clk_sys, .toggle_req(tog), .pin(p0), .tick(tick));
   icu_pair #(.NPAIR(1)) i_dut (.clk_sys, .rst, .capture_control_one(ctl1),
      .capture_control_two(ctl2), .trigger_status_clear(tsc), .overflow_clear(ovc),
      .fifo_pop(pop), .capture_input({p0, p0}), .timebase_tick(tick), .timebase_on(tb_on),
      .sync_event(sev), .sync_source_on(son), .capture_fifo_low_word(lo),
      .capture_fifo_high_word(hi), .fifo_not_empty(ne), .capture_irq(irq), .status(sts),
      .capture_control_one_rd(rd1));

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) if (irq[0] === 1'b1) irqs++;

   // ---------------------------------------------------------------
   // access tasks
   // ---------------------------------------------------------------
   function automatic logic [15:0] m1(logic [2:0] md, logic [1:0] dv, logic [2:0] ts);
      return {3'h0, ts, 3'h0, dv, 2'h0, md};
   endfunction : m1
   function automatic logic [15:0] m2(logic [4:0] ss, logic tr, logic cs);
      return {7'h00, cs, tr, 2'h0, ss};
   endfunction : m2
   task automatic cyc(int n);
      repeat (n) @(negedge clk_sys);
   endtask : cyc
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic results;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : results
   task automatic pulse(ref logic [1:0] s);
      s = 2'b11;
      cyc(1);
      s = 2'b00;
      cyc(1);
   endtask : pulse
   task automatic flip(int n);
      repeat (n) begin
         tog = 1'b1;
         cyc(1);
         tog = 1'b0;
         cyc(1);
      end
   endtask : flip
   task automatic rd_word(output logic [31:0] v);
      int k;
      k = 0;
      while (ne[0] !== 1'b1 && k < 40) begin
         cyc(1);
         k++;
      end
      if (k == 40) begin
         error_cnt++;
         $display("Error fifo_not_empty expected 1 seen %b", ne[0]);
         results;
      end
      v = {hi[0], lo[0]};
      pulse(pop);
   endtask : rd_word
   task automatic setup(logic [15:0] a1, logic [15:0] a2, logic [15:0] b1, logic [15:0] b2);
      son = 32'h0;
      rst = 1'b1;
      cyc(6);
      rst = 1'b0;
      cyc(1);
      for (int k = 0; k < 8 && ne[0] !== 1'b0; k++) pulse(pop);
      ctl2[1] = b2;
      cyc(1);
      ctl2[0] = a2;
      ctl1 = {b1 & 16'hfff8, a1 & 16'hfff8};
      cyc(1);
      ctl1 = {b1, a1};
      irq_base = irqs;
      son = 32'h2;
      cyc(3);
   endtask : setup

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   initial begin
      {rst, tog, ctl1, ctl2, tsc, ovc, pop, sev, son} = '0;
      tb_on = 8'hff;
      setup(m1(BOTH, 2'h0, 3'h0), m2(5'h00, 1'b0, 1'b0), m1(RISE, 2'h0, 3'h1),
         16'h0000);
      flip(1);
      cyc(9);
      flip(1);
      cyc(6);
      chk("irq count", 2, irqs - irq_base);
      chk("control echo", m1(BOTH, 2'h0, 3'h0) | 16'h0008, rd1[0]);
      chk("echo high", m1(RISE, 2'h0, 3'h1) | 16'h0008, rd1[1]);
      chk("status not empty", 1, sts[0].fifo_not_empty);
      rd_word(a);
      chk("first stamp", 32'h0005_0005, a);
      chk("rising only", 0, ne[1]);
      rd_word(b);
      chk("edge delta", 11, 16'(b - a));
      chk("high word", 0, b[31:16]);
      chk("not empty", 0, ne[0]);
      for (int m = 0; m < 3; m++) begin
         setup(m1(mds[m], 2'h0, 3'(m)), m2(5'h00, 1'b0, 1'b0), 16'h0000, 16'h0000);
         flip(2 * cnts[m] - 2);
         cyc(6);
         chk("prescale early", 0, ne[0]);
         flip(2);
         cyc(6);
         chk("prescale fire", 1, ne[0]);
      end
      setup(m1(BOTH, 2'h0, 3'h3), m2(5'h00, 1'b0, 1'b0), 16'h0000, 16'h0000);
      tb_on = 8'hf7;
      cyc(2);
      flip(2);
      cyc(6);
      chk("base off", 0, ne[0]);
      tb_on = 8'h08;
      cyc(2);
      flip(2);
      cyc(6);
      chk("base on", 1, ne[0]);
      tb_on = 8'hff;
      setup(m1(BOTH, 2'h0, 3'h0), m2(5'h00, 1'b0, 1'b0), 16'h0000, 16'h0000);
      repeat (5) begin
         flip(1);
         cyc(3);
      end
      chk("overflow", 1, sts[0].fifo_overflow);
      rd_word(a);
      repeat (3) begin
         rd_word(b);
         chk("fifo delta", 5, 16'(b - a));
         a = b;
      end
      chk("drained", 0, ne[0]);
      pulse(ovc);
      chk("overflow clear", 0, sts[0].fifo_overflow);
      flip(1);
      for (int d = 0; d < 4; d++) begin
         setup(m1(BOTH, 2'(d), 3'h0), m2(5'h00, 1'b0, 1'b0), 16'h0000, 16'h0000);
         flip(4);
         cyc(6);
         chk("irq divider", 4 / (d + 1), irqs - irq_base);
      end
      setup(m1(BOTH, 2'h0, 3'h0), m2(5'h01, 1'b0, 1'b0), 16'h0000, 16'h0000);
      son = 32'h0;
      cyc(2);
      flip(1);
      cyc(6);
      chk("held", 0, ne[0]);
      son = 32'h2;
      cyc(30);
      sev = 32'h2;
      cyc(1);
      sev = 32'h0;
      flip(1);
      rd_word(a);
      chk("sync zero", 1, a[15:0] < 16'h0010);
      setup(m1(BOTH, 2'h0, 3'h0), m2(5'h01, 1'b1, 1'b0), 16'h0000, 16'h0000);
      pulse(tsc);
      flip(1);
      cyc(6);
      chk("trigger wait", 0, {sts[0].trigger_armed_status, ne[0]});
      sev = 32'h2;
      cyc(1);
      sev = 32'h0;
      cyc(2);
      chk("armed", 1, sts[0].trigger_armed_status);
      flip(1);
      cyc(6);
      chk("trigger capture", 1, ne[0]);
      pulse(tsc);
      chk("disarmed", 0, sts[0].trigger_armed_status);
      setup(m1(BOTH, 2'h0, 3'h0), m2(5'h00, 1'b0, 1'b1), m1(BOTH, 2'h0, 3'h0),
         m2(5'h00, 1'b0, 1'b1));
      flip(1);
      cyc(65600);
      flip(1);
      cyc(6);
      chk("pair not empty", 2'b11, ne);
      rd_word(a);
      rd_word(b);
      chk("cascade delta", 65602, b - a);
      results;
   end
endmodule : test_icu_pair
